// file: design/eot_consts.svh
/*
 * Register offsets, field positions, reset values and bit masks for
 * the external over-temperature detector.
 * Assumes an 8-bit register address and 8-bit register data.
 */
`ifndef EOT_CONSTS_SVH
`define EOT_CONSTS_SVH

`define EOT_ADDR_FAULT_CLEAR 8'h02
`define EOT_ADDR_CHG_LIM0 8'h14
`define EOT_ADDR_DIS_LIM0 8'h16
`define EOT_ADDR_CHG_LIM1 8'h18
`define EOT_ADDR_DIS_LIM1 8'h1a
`define EOT_ADDR_PWR_CTRL 8'h24
`define EOT_ADDR_VAL0_LO 8'h58
`define EOT_ADDR_VAL0_HI 8'h59
`define EOT_ADDR_VAL1_LO 8'h5a
`define EOT_ADDR_VAL1_HI 8'h5b
`define EOT_ADDR_FLAGS 8'h64
`define EOT_ADDR_MASKS 8'h84

`define EOT_BIT_CLEAR_ALL 1
`define EOT_BIT_CHG_EN 0
`define EOT_BIT_DIS_EN 1
`define EOT_BIT_AUTO_ISO 2

`define EOT_HEAT_BITS 8'haa
`define EOT_RST_LIMIT 8'h00
`define EOT_RST_PWR 8'h00
`define EOT_RST_MASKS 8'haa
`define EOT_PWR_BITS 8'h07

`endif

// file: design/eot_pkg.sv
/*
 * Types shared by the external over-temperature detector.
 * Assumes eot_consts.svh holds the register offsets, bits, masks and reset values.
 */
package eot_pkg;
    typedef logic [7:0] eot_byte_t;
    typedef enum logic [1:0] {
        EOT_IDLE = 2'b01,
        EOT_CMP = 2'b10
    } eot_state_e;
endpackage

// file: design/eot_limit_check.sv
/*
 * One thermistor channel: compares a captured reading with its charge
 * and discharge limits.
 * Assumes NTC sensing: a lower voltage means a hotter sensor.
 */
`timescale 1ns/1ps
`default_nettype none

module eot_limit_check #(
    parameter int DATA_W = 16,
    parameter int LIM_W = 8
) (
    // captured sample and programmed limits
    input wire logic [DATA_W-1:0] reading,
    input wire logic [LIM_W-1:0] chg_limit,
    input wire logic [LIM_W-1:0] dis_limit,
    // comparison results
    output logic chg_hot,
    output logic dis_hot
);
    // limits are coarse: only the top bits of the sample take part
    wire logic [LIM_W-1:0] coarse;
    assign coarse = reading[DATA_W-1 -: LIM_W];
    assign chg_hot = coarse < chg_limit;
    assign dis_hot = coarse < dis_limit;
endmodule

`default_nettype wire

// file: design/eot_detect.sv
/*
 * External over-temperature detector: threshold registers, sticky
 * fault flags, masked alert output and autonomous power switch cut-off.
 * Assumes a synchronous register port driven by the host interface and
 * thermistor samples that are valid when scan_start pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eot_consts.svh"

module eot_detect #(
    parameter int DATA_W = 16,
    parameter int CHANNELS = 2
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire eot_pkg::eot_byte_t reg_wdata,
    output logic [7:0] reg_rdata,
    // measurement side
    input wire logic scan_start,
    input wire logic [DATA_W-1:0] therm_in_0,
    input wire logic [DATA_W-1:0] therm_in_1,
    output logic scan_done,
    // device outputs
    output logic alert,
    output logic charge_switch_on,
    output logic discharge_switch_on
);
    import eot_pkg::*;

    ////////////////////////////////////////////////////////////////////
    eot_state_e state_r, state_nxt;
    logic [7:0] chg_lim_r [CHANNELS];
    logic [7:0] dis_lim_r [CHANNELS];
    logic [DATA_W-1:0] val_r [CHANNELS];
    logic [7:0] pwr_r, pwr_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] masks_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic alert_r, done_r;
    wire logic [DATA_W-1:0] therm_in [CHANNELS];
    wire logic [CHANNELS-1:0] chg_hot, dis_hot;
    logic [7:0] hits;

    assign therm_in[0] = therm_in_0;
    assign therm_in[1] = therm_in_1;

    wire logic wr_fc = reg_wr && reg_addr == `EOT_ADDR_FAULT_CLEAR;
    wire logic wr_pwr = reg_wr && reg_addr == `EOT_ADDR_PWR_CTRL;
    wire logic wr_mask = reg_wr && reg_addr == `EOT_ADDR_MASKS;
    wire logic clear_all = wr_fc && reg_wdata[`EOT_BIT_CLEAR_ALL];
    wire logic comparing = state_r == EOT_CMP;
    wire logic auto_iso = pwr_r[`EOT_BIT_AUTO_ISO];
    wire logic new_fault = comparing && |hits;

    ////////////////////////////////////////////////////////////////////
    // per-channel limits, samples and comparators
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            wire logic wr_chg = reg_wr &&
                reg_addr == (`EOT_ADDR_CHG_LIM0 + 8'(4 * gi));
            wire logic wr_dis = reg_wr &&
                reg_addr == (`EOT_ADDR_DIS_LIM0 + 8'(4 * gi));
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    chg_lim_r[gi] <= `EOT_RST_LIMIT;
                    dis_lim_r[gi] <= `EOT_RST_LIMIT;
                    val_r[gi] <= '0;
                end else if (ce) begin
                    if (wr_chg) chg_lim_r[gi] <= reg_wdata;
                    if (wr_dis) dis_lim_r[gi] <= reg_wdata;
                    if (state_r == EOT_IDLE && scan_start) begin
                        val_r[gi] <= therm_in[gi];
                    end
                end
            end
            eot_limit_check #(.DATA_W(DATA_W), .LIM_W(8)) u_chk (
                .reading(val_r[gi]),
                .chg_limit(chg_lim_r[gi]),
                .dis_limit(dis_lim_r[gi]),
                .chg_hot(chg_hot[gi]),
                .dis_hot(dis_hot[gi])
            );
            assign hits[4*gi+3] = chg_hot[gi];
            assign hits[4*gi+1] = dis_hot[gi];
            assign hits[4*gi+2] = 1'b0;
            assign hits[4*gi] = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // scan sequencing: capture, then compare one cycle later
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            EOT_IDLE: begin
                if (scan_start) state_nxt = EOT_CMP;
            end
            EOT_CMP: state_nxt = EOT_IDLE;
            default: state_nxt = EOT_IDLE;
        endcase
    end

    // a detection in the clearing cycle survives the clear
    assign flags_nxt = (clear_all ? 8'h00 : flags_r) |
        (comparing ? hits : 8'h00);

    always_comb begin
        pwr_nxt = pwr_r;
        if (wr_pwr) pwr_nxt = reg_wdata & `EOT_PWR_BITS;
        // autonomous cut-off wins over a host write in the same cycle
        if (new_fault && auto_iso) begin
            pwr_nxt[`EOT_BIT_CHG_EN] = 1'b0;
            pwr_nxt[`EOT_BIT_DIS_EN] = 1'b0;
        end
    end

    always_comb begin
        unique case (reg_addr)
            `EOT_ADDR_CHG_LIM0: rdata_nxt = chg_lim_r[0];
            `EOT_ADDR_DIS_LIM0: rdata_nxt = dis_lim_r[0];
            `EOT_ADDR_CHG_LIM1: rdata_nxt = chg_lim_r[1];
            `EOT_ADDR_DIS_LIM1: rdata_nxt = dis_lim_r[1];
            `EOT_ADDR_PWR_CTRL: rdata_nxt = pwr_r;
            `EOT_ADDR_VAL0_LO: rdata_nxt = val_r[0][7:0];
            `EOT_ADDR_VAL0_HI: rdata_nxt = val_r[0][15:8];
            `EOT_ADDR_VAL1_LO: rdata_nxt = val_r[1][7:0];
            `EOT_ADDR_VAL1_HI: rdata_nxt = val_r[1][15:8];
            `EOT_ADDR_FLAGS: rdata_nxt = flags_r;
            `EOT_ADDR_MASKS: rdata_nxt = masks_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= EOT_IDLE;
            flags_r <= 8'h00;
            pwr_r <= `EOT_RST_PWR;
            masks_r <= `EOT_RST_MASKS;
            rdata_r <= 8'h00;
            alert_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            pwr_r <= pwr_nxt;
            if (wr_mask) masks_r <= reg_wdata & `EOT_HEAT_BITS;
            if (reg_rd) rdata_r <= rdata_nxt;
            alert_r <= |(flags_r & ~masks_r & `EOT_HEAT_BITS);
            done_r <= comparing;
        end
    end

    assign reg_rdata = rdata_r;
    assign scan_done = done_r;
    assign alert = alert_r;
    assign charge_switch_on = pwr_r[`EOT_BIT_CHG_EN];
    assign discharge_switch_on = pwr_r[`EOT_BIT_DIS_EN];

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_scan_req;
        ce && state_r == EOT_IDLE && scan_start;
    endsequence
    sequence s_cmp_step;
        ce && comparing;
    endsequence

    AST_SCAN_FLAGS: assert property (
        s_scan_req ##1 s_cmp_step ##0 (hits != 8'h00) |=>
            ((flags_r & $past(hits)) == $past(hits)))
        else $error("scan hit did not set its flag");
    AST_LIMIT_STORE: assert property (
        ce && reg_wr && reg_addr == `EOT_ADDR_DIS_LIM1 |=>
            dis_lim_r[1] == $past(reg_wdata))
        else $error("limit register did not store write");
    AST_FLAG_READ: assert property (
        ce && reg_rd && reg_addr == `EOT_ADDR_FLAGS |=>
            reg_rdata == $past(flags_r))
        else $error("flag read returned wrong value");
    AST_ALERT_MASK: assert property (
        ce && (flags_r & ~masks_r & `EOT_HEAT_BITS) == 8'h00 |=> !alert)
        else $error("alert raised with no unmasked flag");
    AST_AUTO_CUT: assert property (
        s_cmp_step ##0 (auto_iso && hits != 8'h00) |=>
            !charge_switch_on && !discharge_switch_on)
        else $error("switches stayed on after auto fault");
    AST_SWITCH_OFF: assert property (
        ce && wr_pwr && !reg_wdata[`EOT_BIT_CHG_EN] |=> !charge_switch_on)
        else $error("charge switch on after enable cleared");
    AST_CLEAR_ALL: assert property (
        ce && clear_all && !comparing |=> flags_r == 8'h00)
        else $error("clear-all left a flag set");
    AST_STICKY: assert property (
        ce && !clear_all |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("flag dropped without a clear");
endmodule

`default_nettype wire

// file: bench/eot_host_model.sv
/*
 * Host model: register writes, reads and scan requests toward the
 * detector. Assumes one clock, inputs driven at its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module eot_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // measurement side
    output logic scan_start,
    output logic [15:0] therm_in_0,
    output logic [15:0] therm_in_1,
    input wire logic scan_done
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        scan_start = 1'b0;
        therm_in_0 = 16'hffff;
        therm_in_1 = 16'hffff;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // fixed-delay read; data is registered at the read edge and sampled 1.5 cycles later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // samples change after capture, so a late capture shows up
    task automatic scan(input logic [15:0] t0, input logic [15:0] t1,
                        output logic ok);
        ok = 1'b0;
        @(negedge clk_sys);
        scan_start = 1'b1;
        therm_in_0 = t0;
        therm_in_1 = t1;
        @(negedge clk_sys);
        scan_start = 1'b0;
        therm_in_0 = ~t0;
        therm_in_1 = ~t1;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (scan_done === 1'b1) ok = 1'b1;
            @(negedge clk_sys);
        end
    endtask
endmodule

`default_nettype wire

// file: bench/tb.sv
/*
 * Self-checking bench for eot_detect: register calls and scans.
 * Assumes the host model drives the register and scan ports.
 */
`timescale 1ns/1ps
`default_nettype none

`define EOT_CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("unexpected at %0t: got %h want %h", $time, g, e); \
    end \
end

module tb;
    logic clk_sys, srst, ce, reg_wr, reg_rd, scan_start, scan_done;
    logic alert, charge_switch_on, discharge_switch_on, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [15:0] therm_in_0, therm_in_1;
    int n_mismatch = 0;
    int checks_done = 0;
    localparam logic [7:0] RA[9] = '{8'h14, 8'h16, 8'h18, 8'h1a, 8'h24,
        8'h84, 8'h64, 8'h02, 8'h30};
    localparam logic [7:0] RV[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'haa, 8'h00, 8'h00, 8'h00};

    eot_detect dut_u (.clk_sys, .srst, .ce, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .scan_start, .therm_in_0, .therm_in_1,
        .scan_done, .alert, .charge_switch_on, .discharge_switch_on);
    eot_host_model h_u (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .scan_start, .therm_in_0, .therm_in_1, .scan_done);

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        h_u.rd(a, v);
        `EOT_CHK(v, e)
    endtask

    task automatic limits(input logic [7:0] c0, d0, c1, d1);
        h_u.wr(8'h14, c0);
        h_u.wr(8'h16, d0);
        h_u.wr(8'h18, c1);
        h_u.wr(8'h1a, d1);
    endtask

    task automatic do_scan(input logic [15:0] t0, t1);
        h_u.scan(t0, t1, ok);
        `EOT_CHK(ok, 1'b1)
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // about 150 cycles are expected
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        repeat (8) @(negedge clk_sys);
        srst = 1'b0;
        for (int i = 0; i < 9; i++) rdchk(RA[i], RV[i]);
        $display("test reset done");
        limits(8'h80, 8'h40, 8'h40, 8'h80);
        rdchk(8'h16, 8'h40);
        rdchk(8'h1a, 8'h80);
        do_scan(16'h7000, 16'h7000);
        rdchk(8'h64, 8'h28);
        rdchk(8'h59, 8'h70);
        `EOT_CHK(v < 8'h80, 1'b1)
        rdchk(8'h58, 8'h00);
        `EOT_CHK(alert, 1'b0)
        h_u.wr(8'h84, 8'hf7);
        @(negedge clk_sys);
        `EOT_CHK(alert, 1'b1)
        rdchk(8'h84, 8'ha2);
        $display("test detect done");
        h_u.wr(8'h64, 8'h00);
        do_scan(16'hffff, 16'hffff);
        rdchk(8'h64, 8'h28);
        h_u.wr(8'h02, 8'h02);
        rdchk(8'h64, 8'h00);
        `EOT_CHK(alert, 1'b0)
        $display("test sticky done");
        h_u.wr(8'h24, 8'h03);
        @(negedge clk_sys);
        `EOT_CHK({charge_switch_on, discharge_switch_on}, 2'b11)
        h_u.wr(8'h24, 8'h01);
        @(negedge clk_sys);
        `EOT_CHK({charge_switch_on, discharge_switch_on}, 2'b10)
        h_u.wr(8'h24, 8'h03);
        do_scan(16'h7000, 16'h7000);
        `EOT_CHK({charge_switch_on, discharge_switch_on}, 2'b11)
        rdchk(8'h64, 8'h28);
        h_u.wr(8'h24, 8'h00);
        @(negedge clk_sys);
        `EOT_CHK({charge_switch_on, discharge_switch_on}, 2'b00)
        h_u.wr(8'h24, 8'h07);
        do_scan(16'h7000, 16'h7000);
        `EOT_CHK({charge_switch_on, discharge_switch_on}, 2'b00)
        rdchk(8'h24, 8'h04);
        $display("test switches done");
        limits(8'hff, 8'hff, 8'hff, 8'hff);
        h_u.wr(8'h02, 8'h02);
        do_scan(16'h8000, 16'h8000);
        rdchk(8'h64, 8'haa);
        h_u.wr(8'h02, 8'h02);
        limits(8'h00, 8'h00, 8'h00, 8'h00);
        do_scan(16'h0000, 16'h0000);
        rdchk(8'h64, 8'h00);
        ce = 1'b0;
        h_u.wr(8'h14, 8'h55);
        ce = 1'b1;
        rdchk(8'h14, 8'h00);
        $display("test selftest done");
        report_and_stop();
    end
endmodule

`default_nettype wire
